// file: rtl/swd_top.sv
/*
  System watchdog: Wishbone slave registers, enable/disable sequence,
  low-power and debug gating, overflow action as NMI request or reset.
  Assumes i_idle and i_debug come from logic on i_clk, and that the
  system feeds o_sys_reset back into its reset tree.
*/
// The Wishbone register port and the register addresses were chosen for this implementation.
`default_nettype none
`include "swd_cfg.svh"
module swd_top #(
  parameter int P_EXP_BASE = 15,
  parameter int P_HOLD     = `SWD_RESET_STATES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output var  logic [31:0] o_wb_dat,
  output var  logic        o_wb_ack,
  // System status
  input  wire logic        i_idle,
  input  wire logic        i_debug,
  // Watchdog actions
  output var  logic        o_nmi_req,
  output var  logic        o_nmi_flag,
  output var  logic        o_sys_reset,
  output var  logic        o_clk_cfg_default
);
  import swd_pkg::*;

  localparam int CW = P_EXP_BASE + 2 * `SWD_EXP_STEP * 2 + 2;

  swd_top_st_t st_reg;
  swd_top_st_t st_next;
  logic        rst_act;
  logic        req;
  logic        wr;
  logic [7:0]  code;
  logic        fire;

  swd_cnt_if #(.CW(CW)) u_cnt_if ();

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  swd_counter #(
    .P_EXP_BASE (P_EXP_BASE),
    .CW         (CW)
  ) u_counter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (u_cnt_if)
  );

  swd_rst_gen #(
    .P_HOLD (P_HOLD)
  ) u_rst_gen (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_fire   (fire),
    .o_active (rst_act)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Fresh request only; the ack cycle itself is not a new access
  assign req  = i_wb_cyc && i_wb_stb && !st_reg.ack;
  assign wr   = req && i_wb_we && i_wb_sel[0];
  assign code = i_wb_dat[7:0];

  // Reset action only while the watchdog is on; disabled blocks all events
  assign fire = u_cnt_if.ovf && st_reg.act && (st_reg.wd == SWD_ON); // RQ11 RQ22

  // Counter gating by state, debug and idle
  assign u_cnt_if.run   = (st_reg.wd == SWD_ON) && !i_debug // RQ5 RQ8
                          && (!i_idle || st_reg.idle_run) && !rst_act; // RQ7 RQ20
  assign u_cnt_if.per   = st_reg.per;
  assign u_cnt_if.clear = (st_reg.wd == SWD_OFF) || rst_act // RQ22
                          || (wr && i_wb_adr == `SWD_OFS_SERVICE
                              && code == `SWD_CODE_CLEAR); // RQ18

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.ack       = req;
    st_next.nmi_pulse = 1'b0;
    st_next.rdat      = 32'h0000_0000;

    // Register writes
    if (wr) begin
      case (i_wb_adr)
        `SWD_OFS_MODE: begin
          st_next.en       = i_wb_dat[`SWD_MODE_EN];
          st_next.per      = i_wb_dat[`SWD_MODE_PER_HI:`SWD_MODE_PER_LO];
          st_next.idle_run = i_wb_dat[`SWD_MODE_IDLE];
          st_next.act      = i_wb_dat[`SWD_MODE_ACT];
          st_next.b0       = i_wb_dat[`SWD_MODE_B0];
          if (i_wb_dat[`SWD_MODE_EN]) begin
            st_next.wd = SWD_ON; // RQ16
          end
        end
        `SWD_OFS_SERVICE: begin
          // Disable needs the enable bit already cleared, so one stray
          // write cannot stop the watchdog
          if (code == `SWD_CODE_DISABLE && !st_reg.en) begin
            st_next.wd = SWD_OFF; // RQ1 RQ15 RQ21
          end
        end
        `SWD_OFS_FLAGS: begin
          if (i_wb_dat[`SWD_FLAG_WDT]) begin
            st_next.nmi_flag = 1'b0;
          end
        end
        default: begin
          // Unmapped and read-only offsets: write ignored
        end
      endcase
    end

    // Overflow as non-maskable request; set wins over a clear
    if (u_cnt_if.ovf && !st_reg.act && st_reg.wd == SWD_ON) begin
      st_next.nmi_pulse = 1'b1; // RQ9
      st_next.nmi_flag  = 1'b1; // RQ10
    end

    // Read data, captured with the ack
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        `SWD_OFS_MODE: begin
          st_next.rdat[`SWD_MODE_EN]                     = st_reg.en;
          st_next.rdat[`SWD_MODE_PER_HI:`SWD_MODE_PER_LO] = st_reg.per;
          st_next.rdat[`SWD_MODE_IDLE]                   = st_reg.idle_run;
          st_next.rdat[`SWD_MODE_ACT]                    = st_reg.act;
          st_next.rdat[`SWD_MODE_B0]                     = st_reg.b0;
        end
        `SWD_OFS_FLAGS: begin
          st_next.rdat[`SWD_FLAG_WDT] = st_reg.nmi_flag;
        end
        `SWD_OFS_COUNT: begin
          st_next.rdat = 32'(u_cnt_if.count);
        end
        default: begin
          // Service code is write-only and reads zero, as do gaps
          st_next.rdat = 32'h0000_0000; // RQ1
        end
      endcase
    end

    // Internal reset returns every control field to its reset value;
    // the bus keeps answering so software never hangs on an access
    if (rst_act) begin
      st_next.wd        = SWD_ON;
      st_next.en        = `SWD_RST_EN;
      st_next.per       = `SWD_RST_PER;
      st_next.idle_run  = `SWD_RST_IDLE;
      st_next.act       = `SWD_RST_ACT;
      st_next.b0        = 1'b0;
      st_next.nmi_flag  = 1'b0;
      st_next.nmi_pulse = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg          <= '0;
      st_reg.wd       <= SWD_ON;        // RQ5
      st_reg.en       <= `SWD_RST_EN;   // RQ14
      st_reg.per      <= `SWD_RST_PER;  // RQ13
      st_reg.idle_run <= `SWD_RST_IDLE; // RQ20
      st_reg.act      <= `SWD_RST_ACT;  // RQ17
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_wb_dat          = st_reg.rdat;
  assign o_wb_ack          = st_reg.ack;
  assign o_nmi_req         = st_reg.nmi_pulse;
  assign o_nmi_flag        = st_reg.nmi_flag;
  assign o_sys_reset       = rst_act; // RQ11
  // Clock controller returns fsys to the oscillator while this is high
  assign o_clk_cfg_default = rst_act; // RQ12
endmodule // swd_top
`default_nettype wire

// file: inc/swd_cfg.svh
/*
  Constants of the system watchdog: bus offsets, field positions, codes, reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Behaviour
// (RQ1) Write-only service code; 0xB1 disable, 0x4E clear
// (RQ2) Binary counter on system clock, six periods
// (RQ3) Period code 011 gives two-to-the-21 cycles
// (RQ4) Software clears counter before the period elapses
// (RQ5) Counter runs straight after reset release
// (RQ6) Software disables watchdog before deep stop modes
// (RQ7) Idle mode follows the idle run bit
// (RQ8) Counter halts during debug, resumes afterwards
// (RQ9) Action bit 0: overflow raises non-maskable request
// (RQ10) Overflow interrupt sets watchdog bit in flags
// (RQ11) Action bit 1: internal reset for 32 states
// (RQ12) Watchdog reset restores default clock configuration
// (RQ13) Period field resets to 000
// (RQ14) Enable bit resets to 1
// (RQ15) Disable: clear enable, then write 0xB1
// (RQ16) Setting enable bit re-enables, no code needed
// (RQ17) Action bit resets to 1
// (RQ18) Clear code zeroes counter, counting resumes
// (RQ19) Codes 000..101 select exponents 15..25; 110/111 prohibited
// (RQ20) Idle run bit: 0 stops, 1 runs; resets 0
// (RQ21) Early disable code and reserved codes ignored
// (RQ22) Disabled: counter held zero, no events
`ifndef SWD_CFG_SVH
`define SWD_CFG_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SWD_OFS_MODE     8'h00
`define SWD_OFS_SERVICE  8'h04
`define SWD_OFS_FLAGS    8'h08
`define SWD_OFS_COUNT    8'h0C
// ----------------------------------------------------------------------
// Mode register fields, flags register bit and reset values
// ----------------------------------------------------------------------
`define SWD_MODE_EN      7
`define SWD_MODE_PER_HI  6
`define SWD_MODE_PER_LO  4
`define SWD_MODE_IDLE    2
`define SWD_MODE_ACT     1
`define SWD_MODE_B0      0
`define SWD_RST_EN       1'b1
`define SWD_RST_PER      3'h0
`define SWD_RST_IDLE     1'b0
`define SWD_RST_ACT      1'b1
`define SWD_FLAG_WDT     0
// ----------------------------------------------------------------------
// Service codes and timing
// ----------------------------------------------------------------------
`define SWD_CODE_DISABLE 8'hB1
`define SWD_CODE_CLEAR   8'h4E
`define SWD_PER_MAX      3'h5
`define SWD_EXP_STEP     2
`define SWD_RESET_STATES 32
`endif

// file: inc/swd_pkg.sv
/*
  Types shared by the watchdog modules.
  Assumes swd_cfg.svh is on the include path.
*/
`default_nettype none
`include "swd_cfg.svh"
package swd_pkg;
  // Watchdog run state
  typedef enum logic [0:0] {
    SWD_OFF = 1'b0,
    SWD_ON  = 1'b1
  } swd_wd_t;

  // Whole state of the top module
  typedef struct packed {
    swd_wd_t     wd;
    logic        en;
    logic [2:0]  per;
    logic        idle_run;
    logic        act;
    logic        b0;
    logic        nmi_flag;
    logic        nmi_pulse;
    logic        ack;
    logic [31:0] rdat;
  } swd_top_st_t;
endpackage
`default_nettype wire

// file: inc/swd_cnt_if.sv
/*
  Carrier between the watchdog control logic and its counter.
  Assumes one clock domain; control drives, counter answers from flops.
*/
`default_nettype none
interface swd_cnt_if #(
  parameter int CW = 25
);
  logic          run;   // Advance this cycle
  logic          clear; // Force count to zero
  logic [2:0]    per;   // Period code
  logic          ovf;   // One-cycle overflow pulse
  logic [CW-1:0] count; // Current count

  modport ctl (output run, output clear, output per, input ovf, input count);
  modport cnt (input run, input clear, input per, output ovf, output count);
endinterface
`default_nettype wire

// file: rtl/swd_counter.sv
/*
  Watchdog binary counter with selectable power-of-two period.
  Assumes the control side holds clear while the watchdog is off.
*/
`default_nettype none
`include "swd_cfg.svh"
module swd_counter #(
  parameter int P_EXP_BASE = 15,
  parameter int CW         = 25
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  swd_cnt_if.cnt    bus
);
  import swd_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          ovf;
  } swd_cnt_st_t;

  swd_cnt_st_t st_reg;
  swd_cnt_st_t st_next;

  // Last count of a period; prohibited codes fall back to the longest
  function automatic logic [CW-1:0] swd_last(input logic [2:0] code);
    logic [2:0] c;
    int         e;
    c = (code > `SWD_PER_MAX) ? `SWD_PER_MAX : code; // RQ19
    e = P_EXP_BASE + `SWD_EXP_STEP * int'(c); // RQ3
    return CW'((64'h1 << e) - 64'h1);
  endfunction

  // Count, wrap and flag the overflow; a shortened period wraps at once
  always_comb begin
    st_next     = st_reg;
    st_next.ovf = 1'b0;
    if (bus.clear) begin
      st_next.cnt = '0; // RQ18 RQ22
    end else if (bus.run) begin
      if (st_reg.cnt >= swd_last(bus.per)) begin
        st_next.cnt = '0;
        st_next.ovf = 1'b1; // RQ2
      end else begin
        st_next.cnt = st_reg.cnt + CW'(1); // RQ2
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.ovf   = st_reg.ovf;
  assign bus.count = st_reg.cnt;
endmodule // swd_counter
`default_nettype wire

// file: rtl/swd_rst_gen.sv
/*
  Stretches a watchdog reset request to a fixed number of clock states.
  Assumes the trigger is a one-cycle pulse on the same clock.
*/
`default_nettype none
`include "swd_cfg.svh"
module swd_rst_gen #(
  parameter int P_HOLD = `SWD_RESET_STATES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_fire,
  output var  logic o_active
);
  import swd_pkg::*;

  typedef struct packed {
    logic [7:0] left;
    logic       act;
  } swd_rg_st_t;

  swd_rg_st_t st_reg;
  swd_rg_st_t st_next;

  // Retrigger during the hold is ignored; the hold itself clears the source
  always_comb begin
    st_next = st_reg;
    if (i_fire && !st_reg.act) begin
      st_next.act  = 1'b1;
      st_next.left = 8'(P_HOLD - 1); // RQ11
    end else if (st_reg.act) begin
      if (st_reg.left == 8'h00) begin
        st_next.act = 1'b0;
      end else begin
        st_next.left = st_reg.left - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_active = st_reg.act;
endmodule // swd_rst_gen
`default_nettype wire

// file: verif/swd_top_properties.sv
/*
  Port-level checker for swd_top: bus answer, event pulses, reset hold.
  Assumes one clock domain and a bind onto every swd_top.
*/
`default_nettype none
`include "swd_cfg.svh"
module swd_top_chk #(
  parameter int P_HOLD = 32
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_debug,
  input wire logic        o_nmi_req,
  input wire logic        o_nmi_flag,
  input wire logic        o_sys_reset,
  input wire logic        o_clk_cfg_default
);
  // ---
  // Helper logic
  // ---
  // Length of the current reset burst, checked when it ends
  logic [7:0] hold_cnt_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) hold_cnt_reg <= 8'h00;
    else if (o_sys_reset) hold_cnt_reg <= hold_cnt_reg + 8'h01;
    else hold_cnt_reg <= 8'h00;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rst_end;
    o_sys_reset ##1 !o_sys_reset;
  endsequence

  // ---
  // Properties
  // ---
  chk_ack_next: assert property (s_req |=> o_wb_ack)
    else $error("ack missing after request");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_service_reads_zero: assert property (o_wb_ack && !i_wb_we &&
    i_wb_adr == `SWD_OFS_SERVICE |-> o_wb_dat == 32'h0)
    else $error("service register read not zero");
  chk_nmi_pulse: assert property (o_nmi_req |=> !o_nmi_req)
    else $error("nmi request longer than one cycle");
  chk_nmi_flag_set: assert property (o_nmi_req |-> o_nmi_flag)
    else $error("nmi flag not set with request");
  chk_rst_hold: assert property (s_rst_end |-> hold_cnt_reg == 8'(P_HOLD))
    else $error("internal reset length wrong");
  chk_clk_cfg_mirror: assert property (o_clk_cfg_default == o_sys_reset)
    else $error("clock default not with reset");
  chk_debug_halt: assert property ($past(i_debug) && $past(i_debug, 2) &&
    $past(i_debug, 3) |-> !o_nmi_req && !$rose(o_sys_reset))
    else $error("event while in debug");
endmodule // swd_top_chk

bind swd_top swd_top_chk #(.P_HOLD(P_HOLD)) chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_debug(i_debug), .o_nmi_req(o_nmi_req),
  .o_nmi_flag(o_nmi_flag), .o_sys_reset(o_sys_reset),
  .o_clk_cfg_default(o_clk_cfg_default));
`default_nettype wire

// file: verif/tb_top.sv
/*
  Self-checking bench for swd_top with a short period base.
  Assumes the checker file is compiled alongside.
*/
`default_nettype none
`include "swd_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EB = 3; // Shortest period 8 cycles
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_wb_cyc = 1'b0;
  logic        i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [3:0]  i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0;
  logic        i_idle = 1'b0;
  logic        i_debug = 1'b0;
  logic [31:0] o_wb_dat, rd;
  logic        o_wb_ack, o_nmi_req, o_nmi_flag, o_sys_reset, o_clk_cfg_default;
  int          num_errors = 0, compares = 0, nmi_cnt = 0, cycles = 0, snap, n;

  swd_top #(.P_EXP_BASE(EB)) swd_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_idle(i_idle), .i_debug(i_debug), .o_nmi_req(o_nmi_req), .o_nmi_flag(o_nmi_flag),
    .o_sys_reset(o_sys_reset), .o_clk_cfg_default(o_clk_cfg_default));

  initial begin
    forever #2 i_clk = ~i_clk;
  end
  // Event counter and hang limit; whole run is well under this
  always @(posedge i_clk) begin
    cycles++;
    if (o_nmi_req === 1'b1) nmi_cnt++;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ---
  // Shared tasks
  // ---
  task print_verdict();
    $display("checks %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    if (k >= 20) check("bus ack", 1, 0);
  endtask
  task wait_nmi(input int lim);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_nmi_req !== 1'b1 && n < lim);
  endtask

  // ---
  // Scenarios
  // ---
  task t_reset();
    wb(0, `SWD_OFS_MODE, 0);
    check("mode reset", 32'h82, rd);
    n = 0;
    while (o_sys_reset !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    check("reset fired", 1, o_sys_reset);
    check("clock default", 1, o_clk_cfg_default);
    check("nmi quiet", 0, nmi_cnt);
    n = 0;
    while (o_sys_reset === 1'b1 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    check("reset hold", 32, n);
    wb(1, `SWD_OFS_MODE, 32'h80);
    wb(0, `SWD_OFS_SERVICE, 0);
    check("service read", 0, rd);
    wb(0, 8'h10, 0);
    check("unmapped read", 0, rd);
    $display("done reset");
  endtask
  // Period between two free-running overflows for each legal code
  task t_period();
    for (int p = 0; p < 6; p++) begin
      wb(1, `SWD_OFS_MODE, 32'h80 | (p << 4));
      wait_nmi(9000);
      wait_nmi(9000);
      check("period", 1 << (EB + 2 * p), n);
    end
    // Prohibited code must behave as the longest legal period
    wb(1, `SWD_OFS_MODE, 32'hE0);
    wait_nmi(9000);
    wait_nmi(9000);
    check("prohibited period", 1 << (EB + 2 * 5), n);
    check("flag port", 1, o_nmi_flag);
    wb(0, `SWD_OFS_FLAGS, 0);
    check("flag bit", 1, rd);
    wb(1, `SWD_OFS_FLAGS, 1);
    wb(0, `SWD_OFS_FLAGS, 0);
    check("flag cleared", 0, rd);
    $display("done period");
  endtask
  task t_clear();
    wb(1, `SWD_OFS_SERVICE, 32'h4E);
    wb(1, `SWD_OFS_MODE, 32'h90);
    repeat (3) @(posedge i_clk);
    snap = nmi_cnt;
    for (int i = 0; i < 10; i++) begin
      wb(1, `SWD_OFS_SERVICE, 32'h4E);
      repeat (10) @(posedge i_clk);
    end
    check("serviced quiet", snap, nmi_cnt);
    wb(1, `SWD_OFS_SERVICE, 32'h55);
    // Low lane off: this enable clear must be dropped, so 0xB1 stays early
    i_wb_sel <= 4'hE;
    wb(1, `SWD_OFS_MODE, 32'h10);
    i_wb_sel <= 4'hF;
    wb(1, `SWD_OFS_SERVICE, 32'hB1);
    wait_nmi(40);
    check("early disable", 1, o_nmi_req);
    $display("done clear");
  endtask
  task t_lowpower();
    i_debug <= 1'b1;
    repeat (5) @(posedge i_clk);
    snap = nmi_cnt;
    repeat (100) @(posedge i_clk);
    check("debug halt", snap, nmi_cnt);
    i_debug <= 1'b0;
    wait_nmi(40);
    check("debug resume", 1, o_nmi_req);
    i_idle <= 1'b1;
    repeat (5) @(posedge i_clk);
    snap = nmi_cnt;
    repeat (100) @(posedge i_clk);
    check("idle stop", snap, nmi_cnt);
    wb(1, `SWD_OFS_MODE, 32'h94);
    wait_nmi(40);
    check("idle run", 1, o_nmi_req);
    i_idle <= 1'b0;
    $display("done lowpower");
  endtask
  task t_disable();
    wb(1, `SWD_OFS_MODE, 32'h10);
    wb(1, `SWD_OFS_SERVICE, 32'hB1);
    snap = nmi_cnt;
    repeat (100) @(posedge i_clk);
    wb(0, `SWD_OFS_COUNT, 0);
    check("count held", 0, rd);
    check("disabled quiet", snap, nmi_cnt);
    wb(1, `SWD_OFS_MODE, 32'h90);
    wait_nmi(40);
    check("re-enable", 1, o_nmi_req);
    $display("done disable");
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_period();
    t_clear();
    t_lowpower();
    t_disable();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
